/* frame_sync_cfg_params.svh */
`ifndef FRAME_SYNC_CFG_PARAMS_SVH
`define FRAME_SYNC_CFG_PARAMS_SVH

`define ADDR_W 9
`define DATA_W 16
`define REG_COUNT 512
`define ADDR_SEQ_CTRL 9'h0C0
`define ADDR_WIN_LO 9'h0C3
`define ADDR_WIN_HI 9'h0C4
`define ADDR_BLACK 9'h0C5
`define ADDR_DUMMY 9'h0C6
`define ADDR_EXP0 9'h0C7
`define ADDR_EXP1 9'h0C8
`define ADDR_EXP2 9'h0C9
`define ADDR_GAIN 9'h0CC
`define ADDR_FSYNC 9'h0CE
`define ADDR_ROI_FIRST 9'h100
`define ADDR_ROI_LAST 9'h15F
`define ADDR_ROI0_X 9'h100
`define ADDR_ROI0_Y 9'h101
`define BIT_SEQ_EN 0
`define BIT_ROLLING 1
`define BIT_TRIG 4
`define BIT_SLAVE 5
`define BIT_SUBSAMPLE 7
`define BIT_BINNING 8
`define BIT_EXP_SYNC 11
`define BIT_GAIN_LAT 13
`define BIT_BLANK_ROI 8
`define RST_WIN_LO 16'h0001
`define RST_ROI0_X 16'h00FF
`define RST_ROI0_Y 16'h00FF
`define FRAME_CYCLES_DEF 20000
`define SPI_HDR_LAST 5'h09
`define SPI_RD_LEAD 5'h0E
`define SPI_RD_END 5'h1E
`define SPI_WR_LAST 5'h19
`define SPI_CNT_MAX 5'h1F

`endif

/* frame_sync_cfg_pkg.sv */
package frame_sync_cfg_pkg;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b01,
    SEQ_RUN = 2'b10
  } seq_state_e;

  typedef struct packed {
    logic rolling;
    logic subsample;
    logic binning;
    logic [31:0] win_en;
    logic [15:0] black_lines;
    logic [15:0] dummy_lines;
    logic [47:0] exposure;
    logic [15:0] gain;
  } active_cfg_s;

  typedef struct packed {
    logic [8:0] addr;
    logic [15:0] data;
  } wr_req_s;

endpackage

/* frame_sync_cfg.sv */
`timescale 1ns/100ps
`include "frame_sync_cfg_params.svh"

module frame_sync_cfg #(
  parameter int FRAME_CYCLES = `FRAME_CYCLES_DEF
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  output logic spi_miso,
  output logic spi_miso_oe,
  output logic frame_start,
  output logic frame_active,
  output logic training,
  output logic seq_running,
  output frame_sync_cfg_pkg::active_cfg_s active_cfg
);
  import frame_sync_cfg_pkg::*;

  // ==========================================================
  // Reset release
  logic rst_meta_ff;
  logic rst_sync_n;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_ff <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_n <= rst_meta_ff;
    end
  end

  // ==========================================================
  // Serial control port, link clock side
  logic [4:0] bit_cnt_ff;
  logic [24:0] sh_ff;
  logic rd_frame_ff;
  logic [15:0] rd_sh_ff;
  logic miso_ff;
  logic miso_oe_ff;
  logic wr_tgl_ff;
  logic rd_tgl_ff;
  wr_req_s wr_hold_ff;
  logic [8:0] rd_addr_hold_ff;
  logic [15:0] rd_data_ff;
  logic [25:0] frame_word;

  assign frame_word = {sh_ff, spi_mosi};

  // The frame's own select ends all per-frame state, so a stopped clock is harmless.
  always_ff @(posedge spi_sclk or posedge spi_cs_n) begin
    if (spi_cs_n) begin
      bit_cnt_ff <= 5'h00;
      sh_ff <= '0;
      rd_frame_ff <= 1'b0;
    end else begin
      if (bit_cnt_ff != `SPI_CNT_MAX) begin
        bit_cnt_ff <= bit_cnt_ff + 5'h01;
      end
      sh_ff <= frame_word[24:0];
      if (bit_cnt_ff == `SPI_HDR_LAST) begin
        rd_frame_ff <= ~frame_word[9];
      end
    end
  end

  // Write and read requests cross by toggles; the held words stay still until taken.
  always_ff @(posedge spi_sclk or negedge rst_n) begin
    if (!rst_n) begin
      wr_tgl_ff <= 1'b0;
      rd_tgl_ff <= 1'b0;
      wr_hold_ff <= '0;
      rd_addr_hold_ff <= '0;
    end else if (!spi_cs_n) begin
      if (bit_cnt_ff == `SPI_WR_LAST && frame_word[25]) begin
        wr_hold_ff <= '{addr: frame_word[24:16], data: frame_word[15:0]};
        wr_tgl_ff <= ~wr_tgl_ff;
      end
      if (bit_cnt_ff == `SPI_HDR_LAST && !frame_word[9]) begin
        rd_addr_hold_ff <= frame_word[8:0];
        rd_tgl_ff <= ~rd_tgl_ff;
      end
    end
  end

  // Read data leaves on falling edges after four turnaround bits.
  always_ff @(negedge spi_sclk or posedge spi_cs_n) begin
    if (spi_cs_n) begin
      rd_sh_ff <= '0;
      miso_ff <= 1'b0;
      miso_oe_ff <= 1'b0;
    end else if (rd_frame_ff && bit_cnt_ff == `SPI_RD_LEAD) begin
      miso_ff <= rd_data_ff[15];
      rd_sh_ff <= {rd_data_ff[14:0], 1'b0};
      miso_oe_ff <= 1'b1;
    end else if (rd_frame_ff && bit_cnt_ff > `SPI_RD_LEAD && bit_cnt_ff < `SPI_RD_END) begin
      miso_ff <= rd_sh_ff[15];
      rd_sh_ff <= {rd_sh_ff[14:0], 1'b0};
    end else begin
      miso_ff <= 1'b0;
      miso_oe_ff <= 1'b0;
    end
  end

  assign spi_miso = miso_ff;
  assign spi_miso_oe = miso_oe_ff;

  // ==========================================================
  // Crossing into the sensor clock
  logic [2:0] wr_sync_ff;
  logic [2:0] rd_sync_ff;
  logic wr_pulse;
  logic rd_pulse;
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      wr_sync_ff <= 3'h0;
      rd_sync_ff <= 3'h0;
    end else if (ce) begin
      wr_sync_ff <= {wr_sync_ff[1:0], wr_tgl_ff};
      rd_sync_ff <= {rd_sync_ff[1:0], rd_tgl_ff};
    end
  end
  assign wr_pulse = ce & (wr_sync_ff[2] ^ wr_sync_ff[1]);
  assign rd_pulse = ce & (rd_sync_ff[2] ^ rd_sync_ff[1]);

  // ==========================================================
  // Register file
  function automatic logic [15:0] reset_value(input int idx);
    case (idx)
      int'(`ADDR_WIN_LO): reset_value = `RST_WIN_LO;
      int'(`ADDR_ROI0_X): reset_value = `RST_ROI0_X;
      int'(`ADDR_ROI0_Y): reset_value = `RST_ROI0_Y;
      default: reset_value = 16'h0000;
    endcase
  endfunction

  logic [15:0] regs_ff [`REG_COUNT];
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      for (int i = 0; i < `REG_COUNT; i++) begin
        regs_ff[i] <= reset_value(i);
      end
    end else if (wr_pulse) begin
      // Accepted in any sequencer state; black-level, sync-code and pattern
      // registers act at once, so their transients are left to the host.
      regs_ff[wr_hold_ff.addr] <= wr_hold_ff.data;
    end
  end

  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      rd_data_ff <= '0;
    end else if (rd_pulse) begin
      rd_data_ff <= regs_ff[rd_addr_hold_ff];
    end
  end

  logic [15:0] seq_reg;
  logic [15:0] gain_reg;
  logic rolling_now;
  logic exp_direct;
  assign seq_reg = regs_ff[`ADDR_SEQ_CTRL];
  assign gain_reg = regs_ff[`ADDR_GAIN];
  assign rolling_now = seq_reg[`BIT_ROLLING];
  assign exp_direct = !seq_reg[`BIT_ROLLING] && seq_reg[`BIT_TRIG] && !seq_reg[`BIT_SLAVE]
                      && seq_reg[`BIT_EXP_SYNC];

  // ==========================================================
  // Sequencer and frame timing
  seq_state_e seq_state_ff;
  logic [31:0] frame_cnt_ff;
  logic fs_tick;
  logic frame_start_ff;
  logic frame_active_ff;
  assign fs_tick = ce && seq_state_ff == SEQ_RUN && frame_cnt_ff == 32'h0;

  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      seq_state_ff <= SEQ_IDLE;
      frame_cnt_ff <= 32'h0;
    end else if (ce) begin
      case (seq_state_ff)
        SEQ_IDLE: begin
          frame_cnt_ff <= 32'h0;
          if (seq_reg[`BIT_SEQ_EN]) begin
            seq_state_ff <= SEQ_RUN;
          end
        end
        SEQ_RUN: begin
          if (!seq_reg[`BIT_SEQ_EN]) begin
            seq_state_ff <= SEQ_IDLE;
            frame_cnt_ff <= 32'h0;
          end else if (frame_cnt_ff == 32'(FRAME_CYCLES - 1)) begin
            frame_cnt_ff <= 32'h0;
          end else begin
            frame_cnt_ff <= frame_cnt_ff + 32'h1;
          end
        end
        default: begin
          seq_state_ff <= SEQ_IDLE;
          frame_cnt_ff <= 32'h0;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      frame_start_ff <= 1'b0;
      frame_active_ff <= 1'b0;
    end else if (ce) begin
      frame_start_ff <= fs_tick;
      frame_active_ff <= seq_state_ff == SEQ_RUN && seq_reg[`BIT_SEQ_EN];
    end
  end

  // ==========================================================
  // Blank request detection
  logic win_switch;
  logic line_change;
  logic blank_set;
  logic pending_blank_ff;
  logic training_ff;

  // Only a new enable word counts as a switch; window geometry writes never blank.
  assign win_switch = wr_pulse && regs_ff[`ADDR_FSYNC][`BIT_BLANK_ROI] && rolling_now
                      && ((wr_hold_ff.addr == `ADDR_WIN_LO) || (wr_hold_ff.addr == `ADDR_WIN_HI))
                      && wr_hold_ff.data != regs_ff[wr_hold_ff.addr];
  assign line_change = wr_pulse && rolling_now
                       && ((wr_hold_ff.addr == `ADDR_BLACK) || (wr_hold_ff.addr == `ADDR_DUMMY))
                       && wr_hold_ff.data != regs_ff[wr_hold_ff.addr];
  assign blank_set = win_switch || line_change;

  // A request arriving with a frame start is kept for the next frame.
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pending_blank_ff <= 1'b0;
      training_ff <= 1'b0;
    end else if (ce) begin
      pending_blank_ff <= blank_set || (pending_blank_ff && !fs_tick);
      if (fs_tick) begin
        training_ff <= pending_blank_ff;
      end else if (seq_state_ff != SEQ_RUN) begin
        training_ff <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Frame-synchronised active set
  active_cfg_s act_ff;
  logic [47:0] exp_stage_ff;
  logic [15:0] gain_stage_ff;
  logic [47:0] exp_regs;
  assign exp_regs = {regs_ff[`ADDR_EXP2], regs_ff[`ADDR_EXP1], regs_ff[`ADDR_EXP0]};

  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      act_ff <= '0;
      act_ff.win_en <= {16'h0000, `RST_WIN_LO};
      exp_stage_ff <= '0;
      gain_stage_ff <= '0;
    end else if (fs_tick) begin
      act_ff.rolling <= rolling_now;
      act_ff.subsample <= seq_reg[`BIT_SUBSAMPLE];
      act_ff.binning <= seq_reg[`BIT_BINNING];
      act_ff.win_en <= {regs_ff[`ADDR_WIN_HI], regs_ff[`ADDR_WIN_LO]};
      act_ff.black_lines <= regs_ff[`ADDR_BLACK];
      act_ff.dummy_lines <= regs_ff[`ADDR_DUMMY];
      exp_stage_ff <= exp_regs;
      act_ff.exposure <= exp_direct ? exp_regs : exp_stage_ff;
      gain_stage_ff <= gain_reg;
      act_ff.gain <= gain_reg[`BIT_GAIN_LAT] ? gain_stage_ff : gain_reg;
    end
  end

  assign frame_start = frame_start_ff;
  assign frame_active = frame_active_ff;
  assign training = training_ff;
  assign seq_running = frame_active_ff;
  assign active_cfg = act_ff;

  // ==========================================================
  // Checks
  default clocking cb @(posedge mclk iff ce);
  endclocking
  default disable iff (!rst_sync_n);

  sequence frame_edge_s;
    fs_tick;
  endsequence

  sequence blank_req_s;
    blank_set;
  endsequence

  // A blank request is held until a frame start turns it into a training frame.
  sequence blank_pend_s;
    pending_blank_ff;
  endsequence

  frame_pulse_a: assert property (frame_start_ff |=> !frame_start_ff)
    else $error("frame start lasted more than one cycle");
  win_sync_a: assert property ($changed(act_ff.win_en) |-> $past(fs_tick))
    else $error("active windows changed away from a frame start");
  blank_next_a: assert property (blank_pend_s ##0 frame_edge_s |=> training_ff)
    else $error("requested blank frame did not show training");
  blank_hold_a: assert property (blank_req_s |=> pending_blank_ff)
    else $error("blank request was lost");
  training_end_a: assert property (frame_edge_s ##0 !pending_blank_ff |=> !training_ff)
    else $error("training lasted beyond one frame");
  train_idle_a: assert property (seq_state_ff != SEQ_RUN |=> !training_ff)
    else $error("training shown while the sequencer is stopped");
  // In global shutter no new blank request may appear.
  global_noblank_a: assert property (!rolling_now && !pending_blank_ff
                                     |=> !pending_blank_ff)
    else $error("blank requested in global shutter mode");
  switch_blank_a: assert property (win_switch && !fs_tick |=> pending_blank_ff)
    else $error("window switch did not request a blank");
  roi_noblank_a: assert property (wr_pulse && wr_hold_ff.addr >= `ADDR_ROI_FIRST
                                  && wr_hold_ff.addr <= `ADDR_ROI_LAST |-> !blank_set)
    else $error("window geometry write requested a blank");
  // Exposure passes through one stage unless the synchronised trigger mode is chosen.
  exp_latency_a: assert property (fs_tick && !exp_direct
                                  |=> act_ff.exposure == $past(exp_stage_ff))
    else $error("exposure skipped its frame of latency");
  exp_direct_a: assert property (fs_tick && exp_direct
                                 |=> act_ff.exposure == $past(exp_regs))
    else $error("synchronised exposure was delayed");
  exp_stage_a: assert property (frame_edge_s |=> exp_stage_ff == $past(exp_regs))
    else $error("exposure stage not loaded at frame start");
  gain_direct_a: assert property (fs_tick && !gain_reg[`BIT_GAIN_LAT]
                                  |=> act_ff.gain == $past(gain_reg))
    else $error("gain not applied at frame start");
  gain_delay_a: assert property (fs_tick && gain_reg[`BIT_GAIN_LAT]
                                 |=> act_ff.gain == $past(gain_stage_ff))
    else $error("gain compensation delay missing");
  seq_stop_a: assert property (seq_state_ff == SEQ_RUN && !seq_reg[`BIT_SEQ_EN]
                               |=> seq_state_ff == SEQ_IDLE ##1 !frame_start_ff)
    else $error("sequencer did not stop on disable");
  stop_quiet_a: assert property (seq_state_ff == SEQ_IDLE |=> !frame_start_ff)
    else $error("frame start while the sequencer is idle");

endmodule

/* spi_host_model.sv */
`timescale 1ns/100ps
// ==========================================================================
// Serial control port host model
module spi_host_model (
  output logic spi_sclk,
  output logic spi_cs_n,
  output logic spi_mosi,
  input wire logic spi_miso,
  input wire logic spi_miso_oe,
  input wire logic mclk
);
  logic [15:0] rd_data;
  logic miso_seen;
  event rd_ev;

  // A released data line shows the inverse of its last value, so a missing enable
  // turns into a wrong bit.
  assign miso_seen = spi_miso_oe ? spi_miso : ~spi_miso;

  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
    rd_data = 16'h0000;
  end

  // The clock stands still outside frames and mosi only moves while sclk is low.
  // The odd start offset puts every link edge 1.3 ns after a falling mclk edge, in a fixed phase.
  task automatic xfer(input logic [29:0] bits, input int n, input bit rd);
    @(negedge mclk);
    #1.3 spi_cs_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      spi_mosi = (i < 30) ? bits[29 - i] : 1'b0;
      #32 spi_sclk = 1'b1;
      if (rd && i >= 14 && i < 30) begin
        rd_data = {rd_data[14:0], miso_seen};
      end
      #32 spi_sclk = 1'b0;
    end
    #32 spi_cs_n = 1'b1;
    spi_mosi = ~spi_mosi;
    #64;
  endtask

  // Only registers named by the caller are written; reserved ones keep defaults.
  task automatic write_reg(input logic [8:0] addr, input logic [15:0] data);
    xfer({1'b1, addr, data, 4'h0}, 26, 1'b0);
  endtask

  task automatic read_reg(input logic [8:0] addr);
    xfer({1'b0, addr, 20'h00000}, 30, 1'b1);
    ->rd_ev;
  endtask
endmodule

/* testbench.sv */
`timescale 1ns/100ps
`include "frame_sync_cfg_params.svh"
module testbench;
  import frame_sync_cfg_pkg::*;
  typedef struct packed {
    active_cfg_s cfg;
    logic trn;
  } note_s;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic spi_sclk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe;
  logic frame_start, frame_active, training, seq_running;
  active_cfg_s active_cfg;
  int failures = 0;
  int checks_done = 0;
  int cycles = 0;
  note_s notes[$];
  logic [15:0] rd_exp[$];
  logic [15:0] sh[0:511];
  logic [47:0] exp_stage = 48'h0;
  logic [15:0] gain_stage = 16'h0000;
  logic fs_q = 1'b0;
  event fs_ev;

  always #4 mclk = ~mclk;

  frame_sync_cfg #(.FRAME_CYCLES(50)) dut_u (.mclk(mclk), .rst_n(rst_n), .ce(ce),
    .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
    .spi_miso_oe(spi_miso_oe), .frame_start(frame_start), .frame_active(frame_active),
    .training(training), .seq_running(seq_running), .active_cfg(active_cfg));
  spi_host_model host_u (.spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
    .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe), .mclk(mclk));

  // ==========================================================================
  // Compare and closing tasks
  task automatic chk16(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_note(input note_s exp, input note_s got);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED frame config expected %h seen %h", exp, got);
    end
  endtask

  task automatic conclude;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ==========================================================================
  // Reference of the configuration taken at each frame start
  function automatic void advance(input logic blank);
    note_s n;
    logic [15:0] c;
    logic fast;
    c = sh[`ADDR_SEQ_CTRL];
    fast = !c[`BIT_ROLLING] && c[`BIT_TRIG] && !c[`BIT_SLAVE] && c[`BIT_EXP_SYNC];
    n.trn = blank;
    n.cfg.rolling = c[`BIT_ROLLING];
    n.cfg.subsample = c[`BIT_SUBSAMPLE];
    n.cfg.binning = c[`BIT_BINNING];
    n.cfg.win_en = {sh[`ADDR_WIN_HI], sh[`ADDR_WIN_LO]};
    n.cfg.black_lines = sh[`ADDR_BLACK];
    n.cfg.dummy_lines = sh[`ADDR_DUMMY];
    n.cfg.exposure = fast ? {sh[`ADDR_EXP2], sh[`ADDR_EXP1], sh[`ADDR_EXP0]} : exp_stage;
    exp_stage = {sh[`ADDR_EXP2], sh[`ADDR_EXP1], sh[`ADDR_EXP0]};
    n.cfg.gain = sh[`ADDR_GAIN][`BIT_GAIN_LAT] ? gain_stage : sh[`ADDR_GAIN];
    gain_stage = sh[`ADDR_GAIN];
    notes.push_back(n);
  endfunction

  // Writes are made with the mclk side frozen, just after a frame start while running, so the landing
  // frame is known exactly.
  task automatic upd(input logic [8:0] a, input logic [15:0] d, input int nfr);
    logic hit;
    logic blank;
    if (frame_active === 1'b1) begin
      @(fs_ev);
    end else begin
      @(negedge mclk);
    end
    ce = 1'b0;
    hit = (a == `ADDR_BLACK) || (a == `ADDR_DUMMY) ||
      ((a == `ADDR_WIN_LO || a == `ADDR_WIN_HI) && sh[`ADDR_FSYNC][`BIT_BLANK_ROI]);
    blank = sh[`ADDR_SEQ_CTRL][`BIT_ROLLING] && hit && (sh[a] !== d);
    host_u.write_reg(a, d);
    sh[a] = d;
    if (blank) begin
      advance(1'b1);
    end
    @(negedge mclk);
    ce = 1'b1;
    // The write needs a few running cycles to land before the port is used again.
    repeat (4) @(negedge mclk);
    repeat (nfr) @(fs_ev);
  endtask

  task automatic rd(input logic [8:0] a);
    rd_exp.push_back(sh[a]);
    host_u.read_reg(a);
  endtask

  // ==========================================================================
  // Result watchers and timeout
  always @(host_u.rd_ev) begin
    chk16("read data", rd_exp.pop_front(), host_u.rd_data);
  end

  always @(negedge mclk) begin
    if (rst_n === 1'b1 && frame_start === 1'b1 && fs_q !== 1'b1) begin
      if (notes.size() == 0) begin
        advance(1'b0);
      end
      chk_note(notes.pop_front(), {active_cfg, training});
      ->fs_ev;
    end
    fs_q = frame_start;
  end

  always @(posedge mclk) begin
    cycles++;
    if (cycles > 25000) begin
      failures++;
      conclude();
    end
  end

  // ==========================================================================
  // Main sequence
  initial begin
    note_s r;
    void'($urandom(32'h1324d247));
    for (int i = 0; i < 512; i++) begin
      sh[i] = 16'h0000;
    end
    sh[`ADDR_WIN_LO] = `RST_WIN_LO;
    sh[`ADDR_ROI0_X] = `RST_ROI0_X;
    sh[`ADDR_ROI0_Y] = `RST_ROI0_Y;
    repeat (10) @(negedge mclk);
    rst_n = 1'b1;
    repeat (6) @(negedge mclk);
    r = '0;
    r.cfg.win_en = 32'h00000001;
    chk_note(r, {active_cfg, training});
    rd(`ADDR_WIN_LO);
    rd(`ADDR_ROI0_X);
    rd(`ADDR_ROI_LAST);
    $display("test reset values done");
    upd(9'h105, 16'($urandom), 0);
    upd(`ADDR_WIN_HI, 16'h0002, 0);
    upd(`ADDR_GAIN, 16'($urandom) & 16'h1FFF, 0);
    rd(9'h105);
    rd(`ADDR_GAIN);
    $display("test idle writes done");
    upd(`ADDR_SEQ_CTRL, 16'h0003, 2);
    chk16("running", 16'h0003, {14'h0000, frame_active, seq_running});
    upd(`ADDR_GAIN, 16'($urandom) & 16'h1FFF, 2);
    upd(`ADDR_EXP0, 16'($urandom), 3);
    upd(`ADDR_GAIN, 16'h2000 | 16'($urandom), 3);
    $display("test latency done");
    upd(`ADDR_BLACK, 16'h0010, 2);
    upd(`ADDR_DUMMY, 16'h0008, 2);
    upd(`ADDR_FSYNC, 16'h0100, 1);
    upd(`ADDR_WIN_LO, 16'h0004, 2);
    upd(`ADDR_WIN_LO, 16'h0004, 2);
    upd(`ADDR_ROI0_X, 16'h0040, 2);
    rd(`ADDR_ROI0_X);
    $display("test blanking done");
    upd(`ADDR_SEQ_CTRL, 16'h0002, 0);
    repeat (8) @(negedge mclk);
    chk16("stopped", 16'h0000, {14'h0000, frame_active, seq_running});
    // Mode bits change only while the sequencer is stopped.
    upd(`ADDR_SEQ_CTRL, 16'h0990, 0);
    upd(`ADDR_SEQ_CTRL, 16'h0991, 2);
    upd(`ADDR_EXP1, 16'($urandom), 2);
    upd(`ADDR_BLACK, 16'h0020, 2);
    upd(`ADDR_SEQ_CTRL, 16'h0990, 0);
    $display("test global mode done");
    upd(`ADDR_SEQ_CTRL, 16'h09B0, 0);
    upd(`ADDR_SEQ_CTRL, 16'h09B1, 2);
    upd(`ADDR_EXP2, 16'($urandom), 3);
    upd(`ADDR_SEQ_CTRL, 16'h09B0, 0);
    $display("test slave mode done");
    conclude();
  end
endmodule
